// ==== hdl/evt_mask_pkg.sv ====
package evt_mask_pkg;

    // -------------------------------------------------------------------
    // register port geometry
    // -------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_MASK_A    = 8'h29;
    localparam logic [ADDR_W-1:0] ADDR_MASK_B    = 8'h2a;
    localparam logic [ADDR_W-1:0] ADDR_MASK_CONV = 8'h2b;
    localparam logic [ADDR_W-1:0] ADDR_CONV_LIVE = 8'h26;
    localparam logic [ADDR_W-1:0] ADDR_FLAG_A    = 8'h30;
    localparam logic [ADDR_W-1:0] ADDR_FLAG_B    = 8'h31;
    localparam logic [ADDR_W-1:0] ADDR_FLAG_CONV = 8'h32;
    localparam logic [ADDR_W-1:0] ADDR_CLR_A     = 8'h33;
    localparam logic [ADDR_W-1:0] ADDR_CLR_B     = 8'h34;
    localparam logic [ADDR_W-1:0] ADDR_CLR_CONV  = 8'h35;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN    = 8'h36;
    localparam logic [ADDR_W-1:0] ADDR_TOP_LIVE  = 8'h38;

    // -------------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_MASK_A    = 8'h00;
    localparam logic [DATA_W-1:0] RST_MASK_B    = 8'h01;
    localparam logic [DATA_W-1:0] RST_MASK_CONV = 8'h00;
    localparam logic [DATA_W-1:0] RST_IRQ_EN    = 8'h07;
    localparam logic [DATA_W-1:0] ZERO_BYTE     = 8'h00;

    // -------------------------------------------------------------------
    // field positions; flag registers reuse the mask layout, with one pg flag per converter at the pg rise bit
    // -------------------------------------------------------------------
    localparam int BIT_MEAS   = 7;
    localparam int BIT_SYNC   = 3;
    localparam int BIT_THERM  = 1;
    localparam int BIT_REGRST = 0;
    localparam int BIT_B_PGF  = 7;
    localparam int BIT_B_PGR  = 6;
    localparam int BIT_B_PG   = 6;
    localparam int BIT_B_LIM  = 4;
    localparam int BIT_A_PGF  = 3;
    localparam int BIT_A_PGR  = 2;
    localparam int BIT_A_PG   = 2;
    localparam int BIT_A_LIM  = 0;

    // functional bits, the rest is plain storage
    localparam logic [DATA_W-1:0] FUNC_MASK_A    = 8'h8a;
    localparam logic [DATA_W-1:0] FUNC_MASK_B    = 8'h01;
    localparam logic [DATA_W-1:0] FUNC_MASK_CONV = 8'hdd;
    localparam logic [DATA_W-1:0] FLAG_BITS_CONV = 8'h55;

    // irq group enables
    localparam int EN_A    = 0;
    localparam int EN_B    = 1;
    localparam int EN_CONV = 2;

    // live condition vector from the analog side
    localparam int LIVE_THERM = 0;
    localparam int LIVE_A_PG  = 1;
    localparam int LIVE_A_LIM = 2;
    localparam int LIVE_B_PG  = 3;
    localparam int LIVE_B_LIM = 4;
    localparam int LIVE_W     = 5;

endpackage : evt_mask_pkg

// ==== hdl/level_sync2.sv ====
`timescale 1ns/10ps
module level_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule : level_sync2

// ==== hdl/regulator_event_mask_bank.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// How it works
// - mask_a bit 7 set blocks the load measurement ready flag.
// - mask_a bit 3 set blocks the sync clock detection flag.
// - mask_a bit 1 set blocks the thermal warning flag.
// - mask_b bit 0 gates register reset flag; resets to one.
// - conv mask bit 7 blocks converter b power good fall flag.
// - conv mask bit 6 blocks converter b power good rise flag.
// - conv mask bit 4 blocks converter b current limit flag.
// - conv mask bit 3 blocks converter a power good fall flag.
// - conv mask bit 2 blocks converter a power good rise flag.
// - conv mask bit 0 blocks converter a current limit flag.
// - masks never touch live status bits.
// - otp load sets only the functional mask bits; reserved bits keep their stored value.
// ---------------------------------------------------------------------
module regulator_event_mask_bank (
    // clock and reset
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    // register port
    input  wire logic [evt_mask_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [evt_mask_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [evt_mask_pkg::DATA_W-1:0]   reg_rdata,
    // otp defaults
    input  wire logic                              otp_load,
    input  wire logic [evt_mask_pkg::DATA_W-1:0]   otp_mask_a,
    input  wire logic [evt_mask_pkg::DATA_W-1:0]   otp_mask_b,
    input  wire logic [evt_mask_pkg::DATA_W-1:0]   otp_mask_conv,
    // event pulses from on-chip logic
    input  wire logic                              meas_ready_evt,
    input  wire logic                              sync_clk_evt,
    input  wire logic                              reg_reset_evt,
    // live conditions from comparators
    input  wire logic [evt_mask_pkg::LIVE_W-1:0]   live_async,
    // interrupt
    output logic                                   irq
);
    import evt_mask_pkg::*;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    // set wins over clear in the same cycle
    function automatic logic [DATA_W-1:0] flag_next(
        input logic [DATA_W-1:0] cur,
        input logic [DATA_W-1:0] set,
        input logic [DATA_W-1:0] clr
    );
        flag_next = (cur & ~clr) | set;
    endfunction : flag_next

    function automatic logic [DATA_W-1:0] keep_func(
        input logic [DATA_W-1:0] cur,
        input logic [DATA_W-1:0] otp,
        input logic [DATA_W-1:0] func
    );
        keep_func = (otp & func) | (cur & ~func);
    endfunction : keep_func

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [DATA_W-1:0] top_event_mask_a_q;
    logic [DATA_W-1:0] top_event_mask_b_q;
    logic [DATA_W-1:0] converter_event_mask_q;
    logic [DATA_W-1:0] top_flags_a_q;
    logic [DATA_W-1:0] top_flags_b_q;
    logic [DATA_W-1:0] converter_flags_q;
    logic [DATA_W-1:0] irq_enable_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              irq_q;
    logic              irq_d;
    logic [LIVE_W-1:0] live_s;
    logic [LIVE_W-1:0] live_prev_q;

    logic [DATA_W-1:0] set_a;
    logic [DATA_W-1:0] set_b;
    logic [DATA_W-1:0] set_conv;
    logic [DATA_W-1:0] clr_a;
    logic [DATA_W-1:0] clr_b;
    logic [DATA_W-1:0] clr_conv;
    logic [DATA_W-1:0] live_conv;
    logic [DATA_W-1:0] live_top;

    logic therm_rise;
    logic a_pg_rise;
    logic a_pg_fall;
    logic a_lim_rise;
    logic b_pg_rise;
    logic b_pg_fall;
    logic b_lim_rise;

    // -----------------------------------------------------------------
    // live condition capture
    // -----------------------------------------------------------------
    level_sync2 #(
        .W (LIVE_W)
    ) u_live_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (live_async),
        .sync_out (live_s)
    );

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            live_prev_q <= '0;
        end else begin
            live_prev_q <= live_s;
        end
    end

    assign therm_rise = live_s[LIVE_THERM] & ~live_prev_q[LIVE_THERM];
    assign a_pg_rise  = live_s[LIVE_A_PG] & ~live_prev_q[LIVE_A_PG];
    assign a_pg_fall  = ~live_s[LIVE_A_PG] & live_prev_q[LIVE_A_PG];
    assign a_lim_rise = live_s[LIVE_A_LIM] & ~live_prev_q[LIVE_A_LIM];
    assign b_pg_rise  = live_s[LIVE_B_PG] & ~live_prev_q[LIVE_B_PG];
    assign b_pg_fall  = ~live_s[LIVE_B_PG] & live_prev_q[LIVE_B_PG];
    assign b_lim_rise = live_s[LIVE_B_LIM] & ~live_prev_q[LIVE_B_LIM];

    // -----------------------------------------------------------------
    // mask registers
    // -----------------------------------------------------------------
    // otp load wins over a bus write in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            top_event_mask_a_q     <= RST_MASK_A;
            top_event_mask_b_q     <= RST_MASK_B;
            converter_event_mask_q <= RST_MASK_CONV;
        end else if (otp_load) begin
            top_event_mask_a_q     <= keep_func(top_event_mask_a_q, otp_mask_a, FUNC_MASK_A);
            top_event_mask_b_q     <= keep_func(top_event_mask_b_q, otp_mask_b, FUNC_MASK_B);
            converter_event_mask_q <= keep_func(converter_event_mask_q, otp_mask_conv, FUNC_MASK_CONV);
        end else if (reg_wr) begin
            if (reg_addr == ADDR_MASK_A) begin
                top_event_mask_a_q <= reg_wdata;
            end
            if (reg_addr == ADDR_MASK_B) begin
                top_event_mask_b_q <= reg_wdata;
            end
            if (reg_addr == ADDR_MASK_CONV) begin
                converter_event_mask_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_enable_q <= RST_IRQ_EN;
        end else if (reg_wr && reg_addr == ADDR_IRQ_EN) begin
            irq_enable_q <= reg_wdata;
        end
    end

    // -----------------------------------------------------------------
    // flag set terms
    // -----------------------------------------------------------------
    // masks gate only the set path, a mask write never clears a flag
    always_comb begin
        set_a = ZERO_BYTE;
        set_a[BIT_MEAS] = meas_ready_evt & ~top_event_mask_a_q[BIT_MEAS];
        set_a[BIT_SYNC] = sync_clk_evt & ~top_event_mask_a_q[BIT_SYNC];
        set_a[BIT_THERM] = therm_rise & ~top_event_mask_a_q[BIT_THERM];
    end

    always_comb begin
        set_b = ZERO_BYTE;
        set_b[BIT_REGRST] = reg_reset_evt & ~top_event_mask_b_q[BIT_REGRST];
    end

    always_comb begin
        set_conv = ZERO_BYTE;
        set_conv[BIT_B_PG] = (b_pg_fall & ~converter_event_mask_q[BIT_B_PGF])
                           | (b_pg_rise & ~converter_event_mask_q[BIT_B_PGR]);
        set_conv[BIT_B_LIM] = b_lim_rise & ~converter_event_mask_q[BIT_B_LIM];
        set_conv[BIT_A_PG] = (a_pg_fall & ~converter_event_mask_q[BIT_A_PGF])
                           | (a_pg_rise & ~converter_event_mask_q[BIT_A_PGR]);
        set_conv[BIT_A_LIM] = a_lim_rise & ~converter_event_mask_q[BIT_A_LIM];
    end

    assign clr_a    = (reg_wr && reg_addr == ADDR_CLR_A) ? reg_wdata : ZERO_BYTE;
    assign clr_b    = (reg_wr && reg_addr == ADDR_CLR_B) ? reg_wdata : ZERO_BYTE;
    assign clr_conv = (reg_wr && reg_addr == ADDR_CLR_CONV) ? reg_wdata : ZERO_BYTE;

    // -----------------------------------------------------------------
    // flag registers
    // -----------------------------------------------------------------
    // unmasked events latch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            top_flags_a_q     <= ZERO_BYTE;
            top_flags_b_q     <= ZERO_BYTE;
            converter_flags_q <= ZERO_BYTE;
        end else begin
            top_flags_a_q     <= flag_next(top_flags_a_q, set_a, clr_a);
            top_flags_b_q     <= flag_next(top_flags_b_q, set_b, clr_b);
            converter_flags_q <= flag_next(converter_flags_q, set_conv, clr_conv);
        end
    end

    // -----------------------------------------------------------------
    // interrupt output
    // -----------------------------------------------------------------
    // one cycle behind the flags so that the pin comes from a flop
    assign irq_d = (|top_flags_a_q & irq_enable_q[EN_A])
                 | (|top_flags_b_q & irq_enable_q[EN_B])
                 | (|converter_flags_q & irq_enable_q[EN_CONV]);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq = irq_q;

    // -----------------------------------------------------------------
    // read path
    // -----------------------------------------------------------------
    // live bits bypass masks
    always_comb begin
        live_conv = ZERO_BYTE;
        live_conv[BIT_B_PG]  = live_s[LIVE_B_PG];
        live_conv[BIT_B_LIM] = live_s[LIVE_B_LIM];
        live_conv[BIT_A_PG]  = live_s[LIVE_A_PG];
        live_conv[BIT_A_LIM] = live_s[LIVE_A_LIM];
        live_top = ZERO_BYTE;
        live_top[BIT_THERM]  = live_s[LIVE_THERM];
    end

    // clear registers are write-only and read as zero like unmapped ones
    always_comb begin
        case (reg_addr)
            ADDR_MASK_A:    rdata_d = top_event_mask_a_q;
            ADDR_MASK_B:    rdata_d = top_event_mask_b_q;
            ADDR_MASK_CONV: rdata_d = converter_event_mask_q;
            ADDR_CONV_LIVE: rdata_d = live_conv;
            ADDR_TOP_LIVE:  rdata_d = live_top;
            ADDR_FLAG_A:    rdata_d = top_flags_a_q;
            ADDR_FLAG_B:    rdata_d = top_flags_b_q;
            ADDR_FLAG_CONV: rdata_d = converter_flags_q;
            ADDR_IRQ_EN:    rdata_d = irq_enable_q;
            default:        rdata_d = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= ZERO_BYTE;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= ZERO_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_meas_masked: assert property (
        meas_ready_evt && top_event_mask_a_q[BIT_MEAS] && !top_flags_a_q[BIT_MEAS]
        |=> !top_flags_a_q[BIT_MEAS])
        else $error("masked measurement event set its flag");

    a_meas_unmasked: assert property (
        meas_ready_evt && !top_event_mask_a_q[BIT_MEAS]
        |=> top_flags_a_q[BIT_MEAS] ##1 irq_q || !irq_enable_q[EN_A])
        else $error("unmasked measurement event did not raise flag and irq");

    a_sync_gate: assert property (
        $rose(top_flags_a_q[BIT_SYNC]) |-> $past(sync_clk_evt)
        && !$past(top_event_mask_a_q[BIT_SYNC]))
        else $error("sync clock flag rose without an unmasked event");

    a_therm_gate: assert property (
        $rose(top_flags_a_q[BIT_THERM]) |-> $past(therm_rise)
        && !$past(top_event_mask_a_q[BIT_THERM]))
        else $error("thermal flag rose without an unmasked warning");

    a_regrst_default: assert property (
        $past(rst) |-> top_event_mask_b_q == RST_MASK_B && !top_flags_b_q[BIT_REGRST])
        else $error("register reset mask not one after reset");

    a_b_pg_fall: assert property (
        b_pg_fall && converter_event_mask_q[BIT_B_PGF] && !converter_flags_q[BIT_B_PG]
        |=> !converter_flags_q[BIT_B_PG])
        else $error("masked converter b fall set its flag");

    a_b_pg_rise: assert property (
        b_pg_rise && !converter_event_mask_q[BIT_B_PGR] |=> converter_flags_q[BIT_B_PG])
        else $error("unmasked converter b rise missed its flag");

    a_b_lim_gate: assert property (
        $rose(converter_flags_q[BIT_B_LIM]) |-> !$past(converter_event_mask_q[BIT_B_LIM]))
        else $error("masked converter b limit set its flag");

    a_a_pg_fall: assert property (
        a_pg_fall && !converter_event_mask_q[BIT_A_PGF] |=> converter_flags_q[BIT_A_PG])
        else $error("unmasked converter a fall missed its flag");

    a_a_pg_rise: assert property (
        a_pg_rise && converter_event_mask_q[BIT_A_PGR] && !converter_flags_q[BIT_A_PG]
        |=> !converter_flags_q[BIT_A_PG])
        else $error("masked converter a rise set its flag");

    a_a_lim_gate: assert property (
        a_lim_rise && !converter_event_mask_q[BIT_A_LIM] |=> converter_flags_q[BIT_A_LIM])
        else $error("unmasked converter a limit missed its flag");

    a_live_read: assert property (
        reg_rd && reg_addr == ADDR_CONV_LIVE |=> reg_rdata[BIT_A_LIM] == $past(live_s[LIVE_A_LIM])
        && reg_rdata[BIT_B_PG] == $past(live_s[LIVE_B_PG]))
        else $error("live status read differs from live condition");

    a_otp_load: assert property (
        otp_load |=> (converter_event_mask_q & FUNC_MASK_CONV) == ($past(otp_mask_conv) & FUNC_MASK_CONV))
        else $error("otp default not loaded into converter mask");

    a_reserved_store: assert property (
        reg_wr && reg_addr == ADDR_MASK_A && !otp_load ##1 reg_rd && reg_addr == ADDR_MASK_A
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("mask a readback differs from written value");

    a_irq_level: assert property (
        (|converter_flags_q) && irq_enable_q[EN_CONV] |=> irq_q)
        else $error("irq low while an enabled flag is set");

    a_flag_sticky: assert property (
        converter_flags_q[BIT_A_LIM] && !clr_conv[BIT_A_LIM] |=> converter_flags_q[BIT_A_LIM])
        else $error("converter a limit flag dropped without a clear");

    c_meas_flag: cover property (meas_ready_evt && !top_event_mask_a_q[BIT_MEAS] ##2 irq_q);
    c_pg_masked: cover property (b_pg_fall && converter_event_mask_q[BIT_B_PGF]);
    c_set_clear: cover property (set_conv[BIT_A_LIM] && clr_conv[BIT_A_LIM]);
    c_otp_then_wr: cover property (otp_load ##1 reg_wr && reg_addr == ADDR_MASK_B);

endmodule : regulator_event_mask_bank

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    import evt_mask_pkg::*;

    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic              clk_sys       = 1'b0;
    logic              rst           = 1'b1;
    logic [ADDR_W-1:0] reg_addr      = 8'h00;
    logic [DATA_W-1:0] reg_wdata     = 8'h00;
    logic              reg_wr        = 1'b0;
    logic              reg_rd        = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              otp_load      = 1'b0;
    logic [DATA_W-1:0] otp_mask_a    = 8'h00;
    logic [DATA_W-1:0] otp_mask_b    = 8'h00;
    logic [DATA_W-1:0] otp_mask_conv = 8'h00;
    logic              meas_ready_evt = 1'b0;
    logic              sync_clk_evt  = 1'b0;
    logic              reg_reset_evt = 1'b0;
    logic [LIVE_W-1:0] live_async    = 5'h00;
    logic              irq;
    int                num_errors    = 0;
    int                num_checks    = 0;

    regulator_event_mask_bank u_dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .otp_load(otp_load),
        .otp_mask_a(otp_mask_a), .otp_mask_b(otp_mask_b), .otp_mask_conv(otp_mask_conv),
        .meas_ready_evt(meas_ready_evt), .sync_clk_evt(sync_clk_evt),
        .reg_reset_evt(reg_reset_evt), .live_async(live_async), .irq(irq)
    );

    always #20 clk_sys = ~clk_sys;

    // ----------------------------------------------------------------
    // bus cycles and compares
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask : chk_bit

    task automatic pulse(input int src);
        @(posedge clk_sys);
        meas_ready_evt <= (src == 0);
        sync_clk_evt   <= (src == 1);
        reg_reset_evt  <= (src == 2);
        otp_load       <= (src == 9);
        @(posedge clk_sys);
        {meas_ready_evt, sync_clk_evt, reg_reset_evt, otp_load} <= 4'h0;
    endtask : pulse

    // live inputs pass a two-flop synchroniser, so give them time
    task automatic set_live(input int lv, input logic v);
        @(posedge clk_sys);
        live_async[lv] <= v;
        repeat (5) @(posedge clk_sys);
    endtask : set_live

    task automatic give_verdict;
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic check_reset;
        logic [7:0] d;
        logic [7:0] ad [9] = '{8'h29, 8'h2a, 8'h2b, 8'h30, 8'h31, 8'h32, 8'h36, 8'h7f, 8'h33};
        logic [7:0] ex [9] = '{8'h00, RST_MASK_B, 8'h00, 8'h00, 8'h00, 8'h00, RST_IRQ_EN, 8'h00, 8'h00};
        for (int i = 0; i < 9; i++) begin
            rd(ad[i], d);
            chk_byte(d, ex[i]);
        end
        // write then read with no gap, the bus allows it
        @(posedge clk_sys);
        reg_addr  <= ADDR_MASK_A;
        reg_wdata <= 8'h75;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk_sys);
        reg_rd    <= 1'b0;
        #1 chk_byte(reg_rdata, 8'h75);
        wr(ADDR_FLAG_A, 8'hff);
        wr(8'h7f, 8'hff);
        rd(ADDR_MASK_A, d);
        chk_byte(d, 8'h75);
        rd(ADDR_FLAG_A, d);
        chk_byte(d, 8'h00);
        rd(8'h7f, d);
        chk_byte(d, 8'h00);
        chk_bit(irq, 1'b0);
        wr(ADDR_MASK_A, 8'h00);
    endtask : check_reset

    // masked pass then unmasked pass; every other mask bit set in the
    // unmasked pass so a wrong bit position cannot hide
    task automatic evt_case(input int src, input logic fall, input logic [7:0] ma, input int mb,
                            input logic [7:0] fa, input int fb);
        logic [7:0] d;
        logic [7:0] mbit;
        logic [7:0] fbit;
        logic [7:0] la;
        mbit = 8'h01 << mb;
        fbit = 8'h01 << fb;
        la   = (ma == ADDR_MASK_CONV) ? ADDR_CONV_LIVE : ADDR_TOP_LIVE;
        for (int ph = 0; ph < 2; ph++) begin
            wr(ma, 8'hff);
            if (src > 2)
                set_live(src - 3, fall);
            wr(ma, (ph == 1) ? ~mbit : mbit);
            if (src > 2) begin
                set_live(src - 3, !fall);
                rd(la, d);
                chk_bit(d[fb], !fall);
            end else
                pulse(src);
            rd(fa, d);
            chk_byte(d, (ph == 1) ? fbit : 8'h00);
            chk_bit(irq, (ph == 1));
            wr(fa + 8'h03, fbit);
            rd(fa, d);
            chk_byte(d, 8'h00);
            chk_bit(irq, 1'b0);
        end
        wr(ma, 8'hff);
        if (src > 2)
            set_live(src - 3, 1'b0);
        wr(ma, (ma == ADDR_MASK_B) ? RST_MASK_B : 8'h00);
    endtask : evt_case

    task automatic check_sticky;
        logic [7:0] d;
        pulse(0);
        wr(ADDR_MASK_A, 8'h80);
        rd(ADDR_FLAG_A, d);
        chk_byte(d, 8'h80);
        chk_bit(irq, 1'b1);
        wr(ADDR_IRQ_EN, 8'h06);
        repeat (2) @(posedge clk_sys);
        #1 chk_bit(irq, 1'b0);
        wr(ADDR_IRQ_EN, RST_IRQ_EN);
        repeat (2) @(posedge clk_sys);
        #1 chk_bit(irq, 1'b1);
        wr(ADDR_CLR_A, 8'h80);
        wr(ADDR_MASK_A, 8'h00);
    endtask : check_sticky

    // reserved bits keep stored value, functional bits follow otp
    task automatic check_otp;
        logic [7:0] d;
        wr(ADDR_MASK_A, 8'h70);
        @(posedge clk_sys);
        otp_mask_a    <= 8'hff;
        otp_mask_b    <= 8'h00;
        otp_mask_conv <= 8'hff;
        pulse(9);
        rd(ADDR_MASK_A, d);
        chk_byte(d, (8'h70 & ~FUNC_MASK_A) | FUNC_MASK_A);
        rd(ADDR_MASK_B, d);
        chk_byte(d, RST_MASK_B & ~FUNC_MASK_B);
        rd(ADDR_MASK_CONV, d);
        chk_byte(d, FUNC_MASK_CONV);
    endtask : check_otp

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        check_reset;
        evt_case(0, 1'b0, ADDR_MASK_A, BIT_MEAS, ADDR_FLAG_A, BIT_MEAS);
        evt_case(1, 1'b0, ADDR_MASK_A, BIT_SYNC, ADDR_FLAG_A, BIT_SYNC);
        evt_case(2, 1'b0, ADDR_MASK_B, BIT_REGRST, ADDR_FLAG_B, BIT_REGRST);
        evt_case(3 + LIVE_THERM, 1'b0, ADDR_MASK_A, BIT_THERM, ADDR_FLAG_A, BIT_THERM);
        evt_case(3 + LIVE_B_PG, 1'b1, ADDR_MASK_CONV, BIT_B_PGF, ADDR_FLAG_CONV, BIT_B_PG);
        evt_case(3 + LIVE_B_PG, 1'b0, ADDR_MASK_CONV, BIT_B_PGR, ADDR_FLAG_CONV, BIT_B_PG);
        evt_case(3 + LIVE_B_LIM, 1'b0, ADDR_MASK_CONV, BIT_B_LIM, ADDR_FLAG_CONV, BIT_B_LIM);
        evt_case(3 + LIVE_A_PG, 1'b1, ADDR_MASK_CONV, BIT_A_PGF, ADDR_FLAG_CONV, BIT_A_PG);
        evt_case(3 + LIVE_A_PG, 1'b0, ADDR_MASK_CONV, BIT_A_PGR, ADDR_FLAG_CONV, BIT_A_PG);
        evt_case(3 + LIVE_A_LIM, 1'b0, ADDR_MASK_CONV, BIT_A_LIM, ADDR_FLAG_CONV, BIT_A_LIM);
        check_sticky;
        check_otp;
        give_verdict;
    end

    // the tests need about 560 cycles; this allows over fifty times more
    initial begin
        #(40 * 30000);
        num_errors++;
        give_verdict;
    end

endmodule : testbench
